// file: verilog/dds_parallel_config_port.sv
/*
 * Parallel byte-wide address/data configuration port with buffered and
 * active register banks and an update strobe sampled by the sync clock.
 * Assumes the port clock, chip select, direction and bus arrive from an
 * external host and are slow enough to be oversampled by clk.
 */
`default_nettype none

module dds_parallel_config_port
    import dds_port_pkg::*;
#(
    parameter int unsigned SYNC_HALF = 2
) (
    input  wire logic              clk,          // core clock 50 MHz
    input  wire logic              srst,         // sync reset, high
    input  wire logic              ce,           // clock enable
    input  wire logic              portClk,      // host port clock pin
    input  wire logic              csN,          // chip select, low
    input  wire logic              readNotWrite, // high read, low write
    input  wire logic [DATA_W-1:0] busIn,        // bus pin level
    output var  logic [DATA_W-1:0] busOut,       // bus drive value
    output var  logic              busOeN,       // low while driving
    input  wire logic              ioUpdate,     // transfer strobe pin
    output var  logic              syncClkOut,   // sync clock output
    output var  logic [NUM_REGS-1:0][7:0] activeRegs, // active bank
    output var  ctrl_t             ctrl          // decoded controls
);

    // ========================================================
    // pin synchronisers
    localparam int unsigned PIN_W = $bits(pin_in_t);
    localparam pin_in_t PIN_IDLE = '{csN: 1'b1, readNotWrite: 1'b0,
                                     data: '0};

    pin_in_t pinRaw;
    pin_in_t pinSync;
    logic    portClkSync;
    logic    portClkPrev;
    logic    ioUpdSync;

    assign pinRaw = '{csN: csN, readNotWrite: readNotWrite, data: busIn};

    pin_sync #(
        .W         (PIN_W),
        .RESET_VAL (PIN_IDLE)
    ) u_pinSync (
        .clk     (clk),
        .srst    (srst),
        .ce      (ce),
        .asyncIn (pinRaw),
        .syncOut (pinSync)
    );

    pin_sync #(
        .W         (2),
        .RESET_VAL (2'h0)
    ) u_ctlSync (
        .clk     (clk),
        .srst    (srst),
        .ce      (ce),
        .asyncIn ({portClk, ioUpdate}),
        .syncOut ({portClkSync, ioUpdSync})
    );

    always_ff @(posedge clk) begin
        if (srst) begin
            portClkPrev <= 1'b0;
        end else if (ce) begin
            portClkPrev <= portClkSync;
        end
    end

    // ========================================================
    // decode
    // port clock rising edges advance the port
    wire pclkRise = ce & portClkSync & ~portClkPrev;
    wire selected = ~pinSync.csN;

    // ========================================================
    // port state machine
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_DATA,
        ST_DONE
    } port_state_t;

    port_state_t stateReg;
    port_state_t stateNext;
    logic [7:0]  addrReg;
    logic        isReadReg;

    logic [NUM_REGS-1:0][7:0] bufRegs;

    wire addrOk   = (addrReg <= OFS_LAST);
    wire [3:0] addrIdx = addrReg[3:0];
    wire [7:0] readByte = addrOk ? bufRegs[addrIdx] : READ_FILL;
    wire dataEdge = (stateReg == ST_DATA) & pclkRise & selected;
    wire writeHit = dataEdge & ~isReadReg & addrOk;
    wire readHit  = dataEdge & isReadReg;

    always_comb begin
        stateNext = stateReg;
        case (stateReg)
            ST_IDLE: begin
                if (pclkRise && selected) begin
                    stateNext = ST_DATA;
                end
            end
            ST_DATA: begin
                if (pclkRise) begin
                    stateNext = ST_DONE;
                end
            end
            ST_DONE: begin
                if (pclkRise) begin
                    stateNext = ST_IDLE;
                end
            end
            default: begin
                stateNext = ST_IDLE;
            end
        endcase
        if (~selected) begin
            stateNext = ST_IDLE;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            stateReg <= ST_IDLE;
        end else if (ce) begin
            stateReg <= stateNext;
        end
    end

    // address and direction on first edge
    always_ff @(posedge clk) begin
        if (srst) begin
            addrReg   <= 8'h00;
            isReadReg <= 1'b0;
        end else if (pclkRise && selected && stateReg == ST_IDLE) begin
            addrReg   <= pinSync.data;
            isReadReg <= pinSync.readNotWrite;
        end
    end

    // ========================================================
    // bus driver
    // drive read byte after second edge
    always_ff @(posedge clk) begin
        if (srst) begin
            busOut <= 8'h00;
            busOeN <= 1'b1;
        end else if (ce) begin
            if (~selected || (stateReg == ST_DONE && pclkRise)) begin
                busOeN <= 1'b1;
            end else if (readHit) begin
                busOut <= readByte;
                busOeN <= 1'b0;
            end
        end
    end

    // ========================================================
    // buffer bank
    // write byte on second edge
    always_ff @(posedge clk) begin
        if (srst) begin
            bufRegs <= RESET_VALS;
        end else if (writeHit) begin
            bufRegs[addrIdx] <= pinSync.data;
        end
    end

    // ========================================================
    // sync clock divider
    logic [7:0] divCntReg;
    logic       syncClkReg;
    wire        divWrap  = ce & (divCntReg == 8'(SYNC_HALF - 1));
    wire        syncTick = divWrap & ~syncClkReg;

    always_ff @(posedge clk) begin
        if (srst) begin
            divCntReg  <= 8'h00;
            syncClkReg <= 1'b0;
            syncClkOut <= 1'b0;
        end else if (ce) begin
            divCntReg  <= divWrap ? 8'h00 : divCntReg + 8'h01;
            syncClkReg <= divWrap ? ~syncClkReg : syncClkReg;
            syncClkOut <= (divWrap ? ~syncClkReg : syncClkReg)
                          & ~ctrl.syncClkDisable;
        end
    end

    // ========================================================
    // update transfer
    logic updLevelReg;
    wire  updateFire = syncTick & ioUpdSync & ~updLevelReg;

    always_ff @(posedge clk) begin
        if (srst) begin
            updLevelReg <= 1'b0;
        end else if (syncTick) begin
            updLevelReg <= ioUpdSync;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            activeRegs <= RESET_VALS;
        end else if (updateFire) begin
            activeRegs <= bufRegs;
        end
    end

    wire ctrl_t ctrlNext = '{
        lsbFirst:       bufRegs[OFS_CTRL1_B2][LSB_FIRST_BIT],
        profileSel:     bufRegs[OFS_CTRL1_B2][PROFILE_HI_BIT:PROFILE_LO_BIT],
        syncClkDisable: bufRegs[OFS_CTRL1_B2][SYNC_DIS_BIT],
        directSwitch:   bufRegs[OFS_CTRL1_B2][DIRECT_SW_BIT],
        dacFullscaleCode: {bufRegs[OFS_DAC_HI][FSC_HI_BITS-1:0],
                           bufRegs[OFS_DAC_LO]},
        frequencyTuningWordB0: bufRegs[OFS_TUNE_B0]
    };

    wire ctrl_t ctrlReset = '{
        lsbFirst:       RESET_VALS[OFS_CTRL1_B2][LSB_FIRST_BIT],
        profileSel:  RESET_VALS[OFS_CTRL1_B2][PROFILE_HI_BIT:PROFILE_LO_BIT],
        syncClkDisable: RESET_VALS[OFS_CTRL1_B2][SYNC_DIS_BIT],
        directSwitch:   RESET_VALS[OFS_CTRL1_B2][DIRECT_SW_BIT],
        dacFullscaleCode: {RESET_VALS[OFS_DAC_HI][FSC_HI_BITS-1:0],
                           RESET_VALS[OFS_DAC_LO]},
        frequencyTuningWordB0: RESET_VALS[OFS_TUNE_B0]
    };

    always_ff @(posedge clk) begin
        if (srst) begin
            ctrl <= ctrlReset;
        end else if (updateFire) begin
            ctrl <= ctrlNext;
        end
    end

    // ========================================================
    // assertions
    sequence seqAddrPhase;
        stateReg == ST_IDLE && pclkRise && selected;
    endsequence

    sequence seqReadData;
        stateReg == ST_DATA && pclkRise && selected && isReadReg;
    endsequence

    AST_ADDR_TO_DATA: assert property (
        @(posedge clk) disable iff (srst)
        seqAddrPhase |=> stateReg == ST_DATA
    ) else $error("address edge did not enter data phase");

    AST_THIRD_EDGE_IDLE: assert property (
        @(posedge clk) disable iff (srst)
        stateReg == ST_DONE && pclkRise |=> stateReg == ST_IDLE && busOeN
    ) else $error("third edge did not re-initialise port");

    // read data appears after second edge
    AST_READ_DRIVE: assert property (
        @(posedge clk) disable iff (srst)
        seqReadData |=> !busOeN && busOut == $past(readByte)
    ) else $error("read byte not driven after data edge");

    // drive only in read data cycle
    AST_DRIVE_ONLY_READ: assert property (
        @(posedge clk) disable iff (srst)
        !busOeN |-> stateReg == ST_DONE && isReadReg
    ) else $error("bus driven outside read data cycle");

    AST_WRITE_CAPTURE: assert property (
        @(posedge clk) disable iff (srst)
        writeHit |=> bufRegs[$past(addrIdx)] == $past(pinSync.data)
    ) else $error("write byte not stored in buffer");

    AST_CS_ABORT: assert property (
        @(posedge clk) disable iff (srst)
        ce && !selected |=> stateReg == ST_IDLE && busOeN
    ) else $error("select high did not abort access");

    AST_ACTIVE_HOLD: assert property (
        @(posedge clk) disable iff (srst)
        !updateFire |=> $stable(activeRegs)
    ) else $error("active bank changed without update");

    AST_UPDATE_COPY: assert property (
        @(posedge clk) disable iff (srst)
        updateFire |=> activeRegs == $past(bufRegs)
    ) else $error("update did not copy buffer bank");

    AST_UPDATE_ON_TICK: assert property (
        @(posedge clk) disable iff (srst)
        updateFire |=> syncClkReg && updLevelReg
    ) else $error("update fired off a sync tick");

    AST_PROFILE_FIELD: assert property (
        @(posedge clk) disable iff (srst)
        updateFire |=> ctrl.profileSel ==
            activeRegs[OFS_CTRL1_B2][PROFILE_HI_BIT:PROFILE_LO_BIT]
            && ctrl.lsbFirst == activeRegs[OFS_CTRL1_B2][LSB_FIRST_BIT]
    ) else $error("profile field mismatch");

    AST_FSC_ORDER: assert property (
        @(posedge clk) disable iff (srst)
        updateFire |=> ctrl.dacFullscaleCode ==
            {activeRegs[OFS_DAC_HI][FSC_HI_BITS-1:0], activeRegs[OFS_DAC_LO]}
    ) else $error("fullscale code byte order wrong");

endmodule : dds_parallel_config_port

`default_nettype wire

// file: verilog/dds_port_pkg.sv
/*
 * Shared constants, register map and carrier types for the parallel
 * configuration port of the synthesizer.
 * Assumes a single core clock domain; pins are synchronised on entry.
 */
`default_nettype none

package dds_port_pkg;

    // ========================================================
    // bus and map geometry
    localparam int unsigned DATA_W   = 8;
    localparam int unsigned NUM_REGS = 11;

    // ========================================================
    // byte offsets
    localparam logic [7:0] OFS_CTRL1_B0 = 8'h00;
    localparam logic [7:0] OFS_CTRL1_B1 = 8'h01;
    localparam logic [7:0] OFS_CTRL1_B2 = 8'h02;
    localparam logic [7:0] OFS_CTRL1_B3 = 8'h03;
    localparam logic [7:0] OFS_CTRL2_B0 = 8'h04;
    localparam logic [7:0] OFS_CTRL2_B1 = 8'h05;
    localparam logic [7:0] OFS_DAC_LO   = 8'h06;
    localparam logic [7:0] OFS_DAC_HI   = 8'h07;
    localparam logic [7:0] OFS_DAC_RS2  = 8'h08;
    localparam logic [7:0] OFS_DAC_RS3  = 8'h09;
    localparam logic [7:0] OFS_TUNE_B0  = 8'h0a;
    localparam logic [7:0] OFS_LAST     = OFS_TUNE_B0;

    // ========================================================
    // reset values, index 0 in the low byte
    localparam logic [NUM_REGS-1:0][7:0] RESET_VALS = {
        8'h00, 8'h00, 8'h7f, 8'h13, 8'hff, 8'h14,
        8'h32, 8'h00, 8'h00, 8'h00, 8'h00
    };

    // ========================================================
    // field positions
    localparam int unsigned LSB_FIRST_BIT  = 7;
    localparam int unsigned PROFILE_HI_BIT = 6;
    localparam int unsigned PROFILE_LO_BIT = 4;
    localparam int unsigned SYNC_DIS_BIT   = 3;
    localparam int unsigned DIRECT_SW_BIT  = 0;
    localparam int unsigned FSC_HI_BITS    = 2;
    localparam int unsigned FSC_W          = 10;

    localparam logic [7:0] READ_FILL       = 8'h00;

    // ========================================================
    // carrier types
    typedef struct packed {
        logic              csN;
        logic              readNotWrite;
        logic [DATA_W-1:0] data;
    } pin_in_t;

    typedef struct packed {
        logic             lsbFirst;
        logic [2:0]       profileSel;
        logic             syncClkDisable;
        logic             directSwitch;
        logic [FSC_W-1:0] dacFullscaleCode;
        logic [7:0]       frequencyTuningWordB0;
    } ctrl_t;

endpackage : dds_port_pkg

`default_nettype wire

// file: verilog/pin_sync.sv
/*
 * Two-flop synchroniser for a group of asynchronous inputs.
 * Assumes the group changes slowly relative to clk; only the second
 * flop is visible outside.
 */
`default_nettype none

module pin_sync #(
    parameter int unsigned W              = 1,
    parameter logic [W-1:0] RESET_VAL     = '0
) (
    input  wire logic         clk,       // core clock
    input  wire logic         srst,      // sync reset, high
    input  wire logic         ce,        // clock enable
    input  wire logic [W-1:0] asyncIn,   // pin level
    output var  logic [W-1:0] syncOut    // synchronised level
);

    logic [W-1:0] stage1Reg;

    always_ff @(posedge clk) begin
        if (srst) begin
            stage1Reg <= RESET_VAL;
            syncOut   <= RESET_VAL;
        end else if (ce) begin
            stage1Reg <= asyncIn;
            syncOut   <= stage1Reg;
        end
    end

endmodule : pin_sync

`default_nettype wire

// file: test/host_port_model.sv
/*
 * Host side of the parallel configuration port: makes the port clock,
 * chip select, direction and the shared bus, one byte per access.
 * Assumes inputs change on the falling edge of clk; port clock 160 ns.
 */
`default_nettype none

module host_port_model
    import dds_port_pkg::*;
(
    input  wire logic              clk,          // core clock
    input  wire logic [DATA_W-1:0] busOut,       // device drive value
    input  wire logic              busOeN,       // device drives when low
    output var  logic              portClk,      // port clock
    output var  logic              csN,          // chip select, low
    output var  logic              readNotWrite, // high read
    output wire logic [DATA_W-1:0] busIn         // resolved bus level
);
    timeunit 1ns;
    timeprecision 1ps;

    logic       hostDrive;
    logic [7:0] hostData;
    logic [7:0] lastLevel;

    initial begin
        portClk = 1'b0;
        csN = 1'b1;
        readNotWrite = 1'b0;
        hostDrive = 1'b0;
        hostData = 8'h00;
        lastLevel = 8'h00;
    end

    // ========================================================
    // shared wire; a released bus shows the inverse of its last level
    // one shared bus
    assign busIn = !busOeN ? busOut : (hostDrive ? hostData : ~lastLevel);

    always @(posedge clk) begin
        if (!busOeN || hostDrive) lastLevel <= busIn;
    end

    task automatic half();
        repeat (4) @(negedge clk);
    endtask : half

    // ========================================================
    // three clocks, one byte; one clock when aborted
    task automatic access(input logic rd, input logic [7:0] a,
                          input logic [7:0] wd, input logic abort,
                          output logic [7:0] rdata, output logic oe);
        rdata = 8'h00;
        oe = 1'b1;
        @(negedge clk);
        // select, direction, address at edge one
        csN = 1'b0;
        readNotWrite = rd;
        hostDrive = 1'b1;
        hostData = a;
        half();
        portClk = 1'b1;
        half();
        portClk = 1'b0;
        if (abort) begin
            csN = 1'b1;
            hostDrive = 1'b0;
            half();
        end else begin
            // release for read, data for write
            hostDrive = !rd;
            hostData = wd;
            half();
            portClk = 1'b1;
            half();
            portClk = 1'b0;
            repeat (4) @(negedge clk);
            rdata = busIn;
            oe = busOeN;
            portClk = 1'b1;
            half();
            portClk = 1'b0;
            csN = 1'b1;
            hostDrive = 1'b0;
            half();
        end
    endtask : access
endmodule : host_port_model

`default_nettype wire

// file: test/dds_parallel_config_port_tb_top.sv
/*
 * Self-checking bench for the parallel configuration port.
 * Assumes the host model in host_port_model.sv and the port package.
 */
`default_nettype none

module dds_parallel_config_port_tb_top
    import dds_port_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [NUM_REGS-1:0][7:0] RST = {
        8'h00, 8'h00, 8'h7f, 8'h13, 8'hff, 8'h14,
        8'h32, 8'h00, 8'h00, 8'h00, 8'h00
    };

    logic                     clk = 1'b0;
    logic                     srst = 1'b1;
    logic                     ioUpdate = 1'b0;
    logic                     ce = 1'b1;
    logic                     portClk;
    logic                     csN;
    logic                     readNotWrite;
    logic [DATA_W-1:0]        busIn;
    logic [DATA_W-1:0]        busOut;
    logic                     busOeN;
    logic                     syncClkOut;
    logic [NUM_REGS-1:0][7:0] activeRegs;
    logic [NUM_REGS-1:0][7:0] sh;
    ctrl_t                    ctrl;
    int                       failCount = 0;
    int                       cmpCount = 0;
    int                       n;
    logic [7:0]               d;
    logic                     oe;

    always #10 clk = ~clk;

    dds_parallel_config_port i_dds_parallel_config_port (
        .clk(clk), .srst(srst), .ce(ce), .portClk(portClk), .csN(csN),
        .readNotWrite(readNotWrite), .busIn(busIn), .busOut(busOut),
        .busOeN(busOeN), .ioUpdate(ioUpdate), .syncClkOut(syncClkOut),
        .activeRegs(activeRegs), .ctrl(ctrl)
    );

    host_port_model i_host_port_model (
        .clk(clk), .busOut(busOut), .busOeN(busOeN), .portClk(portClk),
        .csN(csN), .readNotWrite(readNotWrite), .busIn(busIn)
    );

    // ========================================================
    // access and comparison tasks
    task automatic giveVerdict();
        $display("compares %0d mismatches %0d", cmpCount, failCount);
        if (failCount == 0 && cmpCount > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : giveVerdict

    task automatic check(input string what, input logic [15:0] seen,
                         input logic [15:0] exp);
        cmpCount++;
        if (seen !== exp) begin
            failCount++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        i_host_port_model.access(1'b1, a, 8'h00, 1'b0, d, oe);
        check("read data", 16'(d), 16'(exp));
        check("read drive", 16'(oe), 16'h0000);
    endtask : rd

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        i_host_port_model.access(1'b0, a, v, 1'b0, d, oe);
        check("write drive", 16'(oe), 16'h0001);
        if (a <= OFS_LAST) sh[a[3:0]] = v;
    endtask : wr

    // strobe held for three sync periods, then a bounded wait
    task automatic doUpdate();
        int k;
        @(negedge clk);
        ioUpdate = 1'b1;
        repeat (12) @(negedge clk);
        ioUpdate = 1'b0;
        for (k = 0; k < 64 && activeRegs !== sh; k++) @(negedge clk);
        if (activeRegs !== sh) begin
            failCount++;
            $display("unexpected update expected %h seen %h", sh, activeRegs);
            giveVerdict();
        end
        repeat (2) @(negedge clk);
    endtask : doUpdate

    task automatic countSync(output int cnt);
        logic p;
        cnt = 0;
        p = syncClkOut;
        repeat (16) begin
            @(negedge clk);
            if (syncClkOut !== p) cnt++;
            p = syncClkOut;
        end
    endtask : countSync

    // ========================================================
    // test sequence
    initial begin
        sh = RST;
        repeat (20) @(negedge clk);
        srst = 1'b0;
        repeat (3) @(negedge clk);
        check("idle drive", 16'(busOeN), 16'h0001);
        for (int i = 0; i < NUM_REGS; i++) begin
            check("active reset", 16'(activeRegs[i]), 16'(RST[i]));
            rd(8'(i), RST[i]);
        end
        $display("test reset values done");

        for (int i = 0; i < NUM_REGS; i++) begin
            wr(8'(i), 8'(i * 29 + 65) & (i == 2 ? 8'hf7 : 8'hff));
        end
        for (int i = 0; i < NUM_REGS; i++) begin
            check("active held", 16'(activeRegs[i]), 16'(RST[i]));
            rd(8'(i), sh[i]);
        end
        doUpdate();
        for (int i = 0; i < NUM_REGS; i++) begin
            check("active", 16'(activeRegs[i]), 16'(sh[i]));
        end
        check("lsb first", 16'(ctrl.lsbFirst), 16'(sh[2][7]));
        check("profile", 16'(ctrl.profileSel), 16'(sh[2][6:4]));
        check("sync off", 16'(ctrl.syncClkDisable), 16'(sh[2][3]));
        check("direct", 16'(ctrl.directSwitch), 16'(sh[2][0]));
        check("fullscale", 16'(ctrl.dacFullscaleCode),
              16'({sh[7][1:0], sh[6]}));
        check("tuning", 16'(ctrl.frequencyTuningWordB0), 16'(sh[10]));
        $display("test write and update done");

        wr(8'h0b, 8'h5a);
        rd(8'h0b, 8'h00);
        rd(8'h0a, sh[10]);
        i_host_port_model.access(1'b0, 8'h01, 8'h00, 1'b1, d, oe);
        check("abort drive", 16'(busOeN), 16'h0001);
        rd(8'h01, sh[1]);
        wr(8'h01, 8'hc3);
        rd(8'h01, 8'hc3);
        $display("test unmapped and abort done");

        @(negedge clk);
        ce = 1'b0;
        countSync(n);
        ce = 1'b1;
        check("frozen sync", 16'(n), 16'h0000);
        countSync(n);
        check("sync running", 16'(n >= 2), 16'h0001);
        wr(8'h02, sh[2] | 8'h88);
        doUpdate();
        check("sync off", 16'(ctrl.syncClkDisable), 16'h0001);
        check("lsb first", 16'(ctrl.lsbFirst), 16'h0001);
        countSync(n);
        check("sync stopped", 16'(n), 16'h0000);
        check("sync level", 16'(syncClkOut), 16'h0000);
        $display("test sync disable done");
        giveVerdict();
    end
endmodule : dds_parallel_config_port_tb_top

`default_nettype wire
